/* File: orc_pkg.sv */
// Purpose: Shared constants and types for the oscillator ready and enable block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Bit positions are those of the status and force-enable registers
package orc_pkg;

   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_FORCE    = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;

   localparam int BIT_EXT  = 7;
   localparam int BIT_FAST = 6;
   localparam int BIT_SLOW = 4;
   localparam int BIT_SEC  = 3;
   localparam int BIT_CONV = 2;
   localparam int BIT_PLL  = 0;

   // Implemented bits of each register
   localparam logic [7:0] STATUS_MASK = 8'hDD;
   localparam logic [7:0] FORCE_MASK  = 8'hDC;
   localparam logic [7:0] FORCE_RESET = 8'h00;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   typedef struct packed {
      logic ext;
      logic fast;
      logic slow;
      logic sec;
      logic conv;
      logic pll;
   } orc_osc_vec_t;

   typedef enum logic [1:0] {
      ORC_BUS_IDLE,
      ORC_BUS_DATA
   } orc_bus_state_t;

endpackage

/* File: orc_ready_sync.sv */
// Purpose: Two-stage synchroniser for the oscillator ready indications
// Assumes: Ready inputs come from oscillator logic in other clock domains
// Notes:   The first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module orc_ready_sync #(
   parameter int WIDTH = 6
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage1_nxt;
   logic [WIDTH-1:0] stage2_nxt;

   always_comb begin
      stage1_nxt = clk_en ? async_in : stage1_r;
      stage2_nxt = clk_en ? stage1_r : sync_out;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage1_r <= '0;
         sync_out <= '0;
      end else begin
         stage1_r <= stage1_nxt;
         sync_out <= stage2_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: orc_top.sv */
// Purpose: Oscillator ready status and manual force-enable over AHB-Lite
// Assumes: Oscillators report their own ready level; requests come from peripherals
// Notes:   Summary of operation follows
//
// Summary of operation
// - Ready flag reads 1 only when usable; external at bit 7, fast internal at 6.
// - Slow internal oscillator readiness reads at status bit 4.
// - Secondary oscillator readiness reads at status bit 3.
// - Converter RC oscillator readiness reads at status bit 2.
// - PLL lock readiness reads at status bit 0.
// - Force bit runs its oscillator; otherwise only peripheral requests run it.
// - Forced external uses config mode; forced fast uses frequency-select value.
`timescale 1ns/1ps
`default_nettype none
module orc_top (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  clk_en,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [7:0]            haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic                  hready,
   input  wire logic [31:0]           hwdata,
   output var  logic [31:0]           hrdata,
   output var  logic                  hreadyout,
   output var  logic                  hresp,
   // Oscillator side
   input  wire orc_pkg::orc_osc_vec_t osc_ready_raw,
   input  wire orc_pkg::orc_osc_vec_t periph_request,
   input  wire logic [2:0]            ext_osc_config_setting,
   input  wire logic [3:0]            fast_osc_frequency_select,
   output var  orc_pkg::orc_osc_vec_t osc_run,
   output var  logic [2:0]            ext_osc_mode,
   output var  logic [3:0]            fast_osc_freq,
   output var  logic                  irq
);

   ////////////////////////////////////////////////////////////////////////
   orc_pkg::orc_osc_vec_t rdy_sync;
   orc_pkg::orc_osc_vec_t rdy_q;

   orc_ready_sync #(
      .WIDTH($bits(orc_pkg::orc_osc_vec_t))
   ) orc_ready_sync_inst (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clk_en  (clk_en),
      .async_in(osc_ready_raw),
      .sync_out(rdy_sync)
   );

   function automatic logic [7:0] pack_status(input orc_pkg::orc_osc_vec_t v);
      logic [7:0] s;
      s = 8'h00;
      s[orc_pkg::BIT_EXT]  = v.ext;
      s[orc_pkg::BIT_FAST] = v.fast;
      s[orc_pkg::BIT_SLOW] = v.slow;
      s[orc_pkg::BIT_SEC]  = v.sec;
      s[orc_pkg::BIT_CONV] = v.conv;
      s[orc_pkg::BIT_PLL]  = v.pll;
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Readiness qualified by running: a stopped source other than the PLL never reads ready
   orc_pkg::orc_osc_vec_t rdy_nxt;
   always_comb begin
      rdy_nxt = rdy_q;
      if (clk_en) begin
         rdy_nxt.ext  = rdy_sync.ext  & osc_run.ext;
         rdy_nxt.fast = rdy_sync.fast & osc_run.fast;
         rdy_nxt.slow = rdy_sync.slow & osc_run.slow;
         rdy_nxt.sec  = rdy_sync.sec  & osc_run.sec;
         rdy_nxt.conv = rdy_sync.conv & osc_run.conv;
         // PLL has no force bit; its ready follows its lock alone
         rdy_nxt.pll  = rdy_sync.pll;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus address phase capture
   orc_pkg::orc_bus_state_t st_r, st_nxt;
   logic [7:0]  addr_r, addr_nxt;
   logic        wr_r, wr_nxt;
   logic [7:0]  force_r, force_nxt;
   logic [7:0]  ien_r, ien_nxt;
   logic [7:0]  ist_r, ist_nxt;
   logic [7:0]  rdy_prev_r;
   logic [31:0] rdata_nxt;
   logic        take;
   logic [7:0]  status_now;
   logic [7:0]  rise;
   orc_pkg::orc_osc_vec_t run_nxt;
   logic [7:0]  rdy_prev_nxt;
   logic [2:0]  mode_nxt;
   logic [3:0]  freq_nxt;
   logic        irq_nxt;

   assign take = hsel & hready & (htrans == orc_pkg::HTRANS_NONSEQ)
                 & (hsize == orc_pkg::HSIZE_WORD);
   assign status_now = pack_status(rdy_q);
   assign rise = status_now & ~rdy_prev_r;

   always_comb begin
      st_nxt    = st_r;
      addr_nxt  = addr_r;
      wr_nxt    = wr_r;
      force_nxt = force_r;
      ien_nxt   = ien_r;
      ist_nxt   = ist_r;
      rdata_nxt = hrdata;
      if (clk_en) begin
         // Data phase of the previous transfer
         if (st_r == orc_pkg::ORC_BUS_DATA && wr_r) begin
            case (addr_r)
               orc_pkg::ADDR_FORCE:
                  force_nxt = hwdata[7:0] & orc_pkg::FORCE_MASK;
               orc_pkg::ADDR_IRQ_EN:
                  ien_nxt = hwdata[7:0] & orc_pkg::STATUS_MASK;
               orc_pkg::ADDR_IRQ_CLR:
                  ist_nxt = ist_r & ~hwdata[7:0];
               default: ;
            endcase
         end
         // New ready rising edge wins over a same-cycle clear
         ist_nxt = ist_nxt | rise;
         if (take) begin
            st_nxt   = orc_pkg::ORC_BUS_DATA;
            addr_nxt = haddr;
            wr_nxt   = hwrite;
            rdata_nxt = 32'h0000_0000;
            if (!hwrite) begin
               case (haddr)
                  orc_pkg::ADDR_STATUS:   rdata_nxt = {24'h00_0000, status_now};
                  orc_pkg::ADDR_FORCE:    rdata_nxt = {24'h00_0000, force_nxt};
                  orc_pkg::ADDR_IRQ_STAT: rdata_nxt = {24'h00_0000, ist_nxt};
                  orc_pkg::ADDR_IRQ_EN:   rdata_nxt = {24'h00_0000, ien_nxt};
                  default:                rdata_nxt = 32'h0000_0000;
               endcase
            end
         end else if (hready) begin
            st_nxt = orc_pkg::ORC_BUS_IDLE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Run requests to the oscillators
   always_comb begin
      run_nxt = osc_run;
      if (clk_en) begin
         run_nxt.ext  = force_r[orc_pkg::BIT_EXT]  | periph_request.ext;
         run_nxt.fast = force_r[orc_pkg::BIT_FAST] | periph_request.fast;
         run_nxt.slow = force_r[orc_pkg::BIT_SLOW] | periph_request.slow;
         run_nxt.sec  = force_r[orc_pkg::BIT_SEC]  | periph_request.sec;
         run_nxt.conv = force_r[orc_pkg::BIT_CONV] | periph_request.conv;
         run_nxt.pll  = periph_request.pll;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge history, copied settings and interrupt level
   always_comb begin
      rdy_prev_nxt = rdy_prev_r;
      mode_nxt     = ext_osc_mode;
      freq_nxt     = fast_osc_freq;
      irq_nxt      = irq;
      if (clk_en) begin
         rdy_prev_nxt = status_now;
         mode_nxt     = ext_osc_config_setting;
         freq_nxt     = fast_osc_frequency_select;
         irq_nxt      = |(ist_nxt & ien_nxt);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r          <= orc_pkg::ORC_BUS_IDLE;
         addr_r        <= 8'h00;
         wr_r          <= 1'b0;
         force_r       <= orc_pkg::FORCE_RESET;
         ien_r         <= orc_pkg::IRQ_EN_RESET;
         ist_r         <= 8'h00;
         rdy_prev_r    <= 8'h00;
         rdy_q         <= '0;
         hrdata        <= 32'h0000_0000;
         hreadyout     <= 1'b1;
         hresp         <= 1'b0;
         osc_run       <= '0;
         ext_osc_mode  <= 3'h0;
         fast_osc_freq <= 4'h0;
         irq           <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         addr_r    <= addr_nxt;
         wr_r      <= wr_nxt;
         force_r   <= force_nxt;
         ien_r     <= ien_nxt;
         ist_r     <= ist_nxt;
         rdy_q     <= rdy_nxt;
         hrdata    <= rdata_nxt;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         osc_run   <= run_nxt;
         rdy_prev_r    <= rdy_prev_nxt;
         ext_osc_mode  <= mode_nxt;
         fast_osc_freq <= freq_nxt;
         irq           <= irq_nxt;
      end
   end

endmodule
`default_nettype wire

/* File: orc_props.sv */
// Purpose: Port checker for orc_top
// Assumes: hready is fed back from hreadyout
// Notes:   Bound to every orc_top instance below
`timescale 1ns/1ps
`default_nettype none
module orc_props (
   input wire logic                  hclk,
   input wire logic                  hresetn,
   input wire logic                  clk_en,
   input wire logic                  hsel,
   input wire logic [7:0]            haddr,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic [2:0]            hsize,
   input wire logic [31:0]           hrdata,
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   input wire orc_pkg::orc_osc_vec_t osc_ready_raw,
   input wire orc_pkg::orc_osc_vec_t periph_request,
   input wire logic [2:0]            ext_osc_config_setting,
   input wire logic [3:0]            fast_osc_frequency_select,
   input wire orc_pkg::orc_osc_vec_t osc_run,
   input wire logic [2:0]            ext_osc_mode,
   input wire logic [3:0]            fast_osc_freq
);
   wire logic rd_stat = clk_en && hsel && hreadyout && htrans == orc_pkg::HTRANS_NONSEQ
                        && !hwrite && hsize == orc_pkg::HSIZE_WORD
                        && haddr == orc_pkg::ADDR_STATUS;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("slave not ready or not okay");
   // Sampled reset in the antecedent: the release edge still shows reset values
   a_run_request: assert property (clk_en && hresetn
      |=> (osc_run & $past(periph_request)) == $past(periph_request))
      else $error("requested oscillator not running");
   a_pll_request: assert property (clk_en && hresetn
      |=> osc_run.pll == $past(periph_request.pll))
      else $error("pll run differs from request");
   a_ext_mode: assert property (clk_en && hresetn
      |=> ext_osc_mode == $past(ext_osc_config_setting))
      else $error("external mode not copied");
   a_fast_freq: assert property (clk_en && hresetn
      |=> fast_osc_freq == $past(fast_osc_frequency_select))
      else $error("fast frequency not copied");
   a_unused_zero: assert property (hrdata[31:8] == 24'h0 && !hrdata[5] && !hrdata[1])
      else $error("unused read bit set");
   a_ext_not_ready: assert property ((!osc_ready_raw.ext) [*5] ##0 rd_stat
      |=> !hrdata[7])
      else $error("external flag set while not ready");
   a_pll_not_ready: assert property ((!osc_ready_raw.pll) [*5] ##0 rd_stat
      |=> !hrdata[0])
      else $error("pll flag set while not locked");
endmodule
bind orc_top orc_props orc_props_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_ready_raw(osc_ready_raw),
   .periph_request(periph_request), .ext_osc_config_setting(ext_osc_config_setting),
   .fast_osc_frequency_select(fast_osc_frequency_select), .osc_run(osc_run),
   .ext_osc_mode(ext_osc_mode), .fast_osc_freq(fast_osc_freq));
`default_nettype wire

/* File: tb_orc_top.sv */
// Purpose: Self-checking bench for orc_top
// Assumes: Zero-wait slave, hready fed back from hreadyout
// Notes:   Random force, request and ready mixes with corner cases
`timescale 1ns/1ps
`default_nettype none
module tb_orc_top;
   logic                  hclk = 1'b0;
   logic                  hresetn = 1'b0;
   logic                  ce = 1'b1;
   logic                  hwrite = 1'b0;
   logic [7:0]            haddr = 8'h00;
   logic [1:0]            htrans = 2'h0;
   logic [31:0]           hwdata = 32'h0;
   logic [31:0]           hrdata, q, f;
   logic                  hreadyout, hresp, irq;
   logic [2:0]            cfg = 3'h0, ext_osc_mode;
   logic [3:0]            frq = 4'h0, fast_osc_freq;
   orc_pkg::orc_osc_vec_t rdy = '0, req = '0, osc_run, req_old;
   int                    fails = 0, n_tests = 0;
   orc_top orc_top_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(ce), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(orc_pkg::HSIZE_WORD),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .osc_ready_raw(rdy), .periph_request(req), .ext_osc_config_setting(cfg),
      .fast_osc_frequency_select(frq), .osc_run(osc_run), .ext_osc_mode(ext_osc_mode),
      .fast_osc_freq(fast_osc_freq), .irq(irq));
   initial forever #50 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [5:0] exp_run(input logic [7:0] fv, input logic [5:0] rv);
      return {fv[7], fv[6], fv[4], fv[3], fv[2], 1'b0} | rv;
   endfunction
   function automatic logic [31:0] exp_stat(input logic [5:0] rd, input logic [5:0] run);
      logic [5:0] m;
      m = rd & {run[5:1], 1'b1};
      return {24'h0, m[5], m[4], 1'b0, m[3], m[2], m[1], 1'b0, m[0]};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Holds each phase until hready is seen high, as the bus demands
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      haddr <= a;
      hwrite <= w;
      htrans <= orc_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #(100 * 20000);
      fails++;
      conclude();
   end
   initial begin
      void'($urandom(32'hFDB8));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      bus(orc_pkg::ADDR_FORCE, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      for (int i = 0; i < 12; i++) begin
         f = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $urandom;
         @(posedge hclk);
         req <= (i == 1) ? 6'h3F : (i == 0) ? 6'h00 : 6'($urandom);
         rdy <= (i < 2) ? 6'h3F : 6'($urandom);
         cfg <= 3'($urandom);
         frq <= 4'($urandom);
         bus(orc_pkg::ADDR_FORCE, 1'b1, f, q);
         bus(orc_pkg::ADDR_FORCE, 1'b0, 32'h0, q);
         chk(q, {24'h0, f[7:0] & orc_pkg::FORCE_MASK});
         repeat (6) @(posedge hclk);
         chk(32'(osc_run), 32'(exp_run(f[7:0], req)));
         chk(32'({ext_osc_mode, fast_osc_freq}), 32'({cfg, frq}));
         // Write to the read-only status must leave it alone
         bus(orc_pkg::ADDR_STATUS, 1'b1, 32'hFF, q);
         bus(orc_pkg::ADDR_STATUS, 1'b0, 32'h0, q);
         chk(q, exp_stat(rdy, exp_run(f[7:0], req)));
      end
      // Mid-run reset clears the force bits while requests keep running
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(orc_pkg::ADDR_FORCE, 1'b0, 32'h0, q);
      chk(q, {24'h0, orc_pkg::FORCE_RESET});
      chk(32'(osc_run), 32'(exp_run(orc_pkg::FORCE_RESET, req)));
      // Clock enable low freezes the run outputs
      @(posedge hclk);
      ce <= 1'b0;
      req_old = req;
      req <= ~req;
      repeat (4) @(posedge hclk);
      chk(32'(osc_run), 32'(exp_run(orc_pkg::FORCE_RESET, req_old)));
      ce <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(32'(osc_run), 32'(exp_run(orc_pkg::FORCE_RESET, req)));
      bus(8'h20, 1'b1, 32'hFF, q);
      bus(8'h20, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      @(posedge hclk);
      rdy <= '0;
      bus(orc_pkg::ADDR_IRQ_EN, 1'b1, 32'hFF, q);
      bus(orc_pkg::ADDR_IRQ_EN, 1'b0, 32'h0, q);
      chk(q, 32'hDD);
      repeat (6) @(posedge hclk);
      bus(orc_pkg::ADDR_IRQ_CLR, 1'b1, 32'hFF, q);
      repeat (3) @(posedge hclk);
      chk(32'(irq), 32'h0);
      @(posedge hclk);
      rdy <= 6'h01;
      repeat (6) @(posedge hclk);
      chk(32'(irq), 32'h1);
      bus(orc_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0, q);
      chk(q, 32'h01);
      bus(orc_pkg::ADDR_IRQ_EN, 1'b1, 32'h0, q);
      repeat (3) @(posedge hclk);
      chk(32'(irq), 32'h0);
      bus(orc_pkg::ADDR_IRQ_CLR, 1'b1, 32'h01, q);
      bus(orc_pkg::ADDR_IRQ_EN, 1'b1, 32'hFF, q);
      repeat (3) @(posedge hclk);
      chk(32'(irq), 32'h0);
      conclude();
   end
endmodule
`default_nettype wire
